// File: design/scb_regs.vh
`ifndef SCB_REGS_VH
`define SCB_REGS_VH
// ==============================
// Register offsets
`define SCB_ADDR_W 16
`define SCB_OFF_CLKSEL 16'h2004
`define SCB_OFF_CMD 16'h2008
`define SCB_OFF_BUF 16'h200C
`define SCB_OFF_IPC 16'h2010
`define SCB_OFF_CTRL 16'h2020
`define SCB_OFF_STAT 16'h2024
// ==============================
// Field positions (bit 0 = lsb of bus word)
`define SCB_RXCS_LSB 4
`define SCB_TXCS_LSB 0
`define SCB_MISC_LSB 4
`define SCB_TXC_LSB 2
`define SCB_RXC_LSB 0
// ==============================
// Codes
`define SCB_CS_PRESCALED 4'hD
`define SCB_CS_PIN_DIV16 4'hE
`define SCB_CS_PIN 4'hF
`define SCB_MISC_NONE 3'h0
`define SCB_MISC_PTR 3'h1
`define SCB_MISC_RXRST 3'h2
`define SCB_MISC_TXRST 3'h3
`define SCB_MISC_ERRRST 3'h4
`define SCB_MISC_DBRST 3'h5
`define SCB_MISC_BRKON 3'h6
`define SCB_MISC_BRKOFF 3'h7
`define SCB_EN_CODE 2'h1
`define SCB_DIS_CODE 2'h2
// ==============================
// Modes in control register
`define SCB_MODE_UART 2'h0
`define SCB_MODE_MOD8 2'h1
`define SCB_MODE_MOD16 2'h2
`define SCB_MODE_AC97 2'h3
// ==============================
// Reset values and timing
`define SCB_CLKSEL_RST 8'h00
`define SCB_CTRL_RST 8'h00
`define SCB_DIV16 4'hF
`endif

// File: design/scb_fifo_mem.v
`timescale 1ns/1ps
`default_nettype none
// ==============================
// Small FIFO storage, registered read
module scb_fifo_mem #(
	parameter W = 20,
	parameter AW = 4
) (
	input wire clk,
	input wire we,
	input wire [AW-1:0] waddr,
	input wire [W-1:0] wdata,
	input wire [AW-1:0] raddr,
	output reg [W-1:0] rdata
);
	reg [W-1:0] mem [0:(1<<AW)-1];
	always @(posedge clk)
	begin
		if (we)
			mem[waddr] <= wdata;
		rdata <= mem[raddr];
	end
endmodule // scb_fifo_mem
`default_nettype wire

// File: design/scb_clk_sel.v
`timescale 1ns/1ps
`default_nettype none
`include "scb_regs.vh"
// ==============================
// Channel bit-clock selector
module scb_clk_sel (
	input wire clk,
	input wire resetn,
	input wire [3:0] sel,
	input wire prescaled_tick,
	input wire pin_rise,
	output reg tick
);
	reg [3:0] div_q;
	reg tick_d;
	always @*
	begin
		case (sel)
			`SCB_CS_PRESCALED: tick_d = prescaled_tick;
			`SCB_CS_PIN_DIV16: tick_d = pin_rise && (div_q == `SCB_DIV16);
			`SCB_CS_PIN: tick_d = pin_rise;
			default: tick_d = 1'b0;
		endcase
	end
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			div_q <= 4'h0;
			tick <= 1'b0;
		end
		else
		begin
			if (pin_rise)
				div_q <= div_q + 4'h1;
			tick <= tick_d;
		end
	end
endmodule // scb_clk_sel
`default_nettype wire

// File: design/scb_core.v
// Functional notes
// RULE1 - Rx clock code D prescaled core, E timer pin /16, F pin direct.
// RULE2 - Tx clock has its own field with the same three codes.
// RULE3 - Software never combines conflicting commands in one command write.
// RULE4 - Misc code 0 does nothing; code 1 rewinds mode pointer.
// RULE5 - Misc 2 disables receiver, clears full and ready, resets Rx FIFO.
// RULE6 - Misc 3 disables transmitter, clears flags; modem keeps empty set.
// RULE7 - Misc 4 clears error flags; in modem mode also clears empty.
// RULE8 - Misc 5 clears delta-break flag except in modem mode.
// RULE9 - Misc 6 drives line low after current character, held later.
// RULE10 - Break start needs transmitter enabled, ignores CTS, not modem.
// RULE11 - Misc 7 returns line to mark, then queued characters continue.
// RULE12 - Tx code 1 enables and sets empty and ready; idempotent. The code sets both flags in UART mode only.
// RULE13 - Modem: Tx FIFO writable while disabled; empty sets at frame sync.
// RULE14 - AC97: empty sets on sync if FIFO empty, enabled, codec ready.
// RULE15 - Tx code 2 stops after character and clears empty and ready. In modem mode the code keeps empty, and keeps ready unless remote loopback.
// RULE16 - Rx code 1 enables receiver, hunting start bit unless multidrop.
// RULE17 - Rx code 2 drops partial character; loopback or multidrop keep.
// RULE18 - Modem: disabling mid-character finishes that character first.
// RULE19 - 8-bit read packs four characters, earliest in top byte.
// RULE20 - 16-bit read returns two samples.
// RULE21 - AC97 word carries start-of-frame; tag slot sits in bits 19:4.
// RULE22 - Tx buffer write queues upper word before lower ones.
`timescale 1ns/1ps
`default_nettype none
`include "scb_regs.vh"
module scb_core #(
	parameter AW = 4,
	parameter PRESCALE = 16
) (
	input wire clk,
	input wire resetn,
	input wire [15:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire rd,
	output reg [31:0] rdata,
	input wire external_timer_pin,
	input wire rx_line,
	input wire frame_sync,
	input wire codec_ready,
	output reg tx_line,
	output reg mode_ptr_reset,
	output wire rx_enabled,
	output wire tx_enabled
);
	// ==============================
	// Local constants and states
	localparam DEPTH = 1 << AW;
	localparam TS_IDLE = 2'd0;
	localparam TS_LOAD = 2'd1;
	localparam TS_SHIFT = 2'd2;
	localparam RS_IDLE = 1'b0;
	localparam RS_SHIFT = 1'b1;
	function [1:0] cnt_sub;
		input [1:0] c;
		cnt_sub = c - 2'd1;
	endfunction
	// ==============================
	// Pin synchronisers
	reg [1:0] pin_s_q, rxl_s_q, fs_s_q, cr_s_q;
	reg pin_prev_q, fs_prev_q;
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pin_s_q <= 2'b00;
			rxl_s_q <= 2'b11;
			fs_s_q <= 2'b00;
			cr_s_q <= 2'b00;
			pin_prev_q <= 1'b0;
			fs_prev_q <= 1'b0;
		end
		else
		begin
			pin_s_q <= {pin_s_q[0], external_timer_pin};
			rxl_s_q <= {rxl_s_q[0], rx_line};
			fs_s_q <= {fs_s_q[0], frame_sync};
			cr_s_q <= {cr_s_q[0], codec_ready};
			pin_prev_q <= pin_s_q[1];
			fs_prev_q <= fs_s_q[1];
		end
	end
	wire pin_rise = pin_s_q[1] & ~pin_prev_q;
	wire fs_rise = fs_s_q[1] & ~fs_prev_q;
	wire rx_in = rxl_s_q[1];
	// ==============================
	// Registers
	reg [7:0] clksel_q, ctrl_q;
	reg [15:0] pre_q;
	wire pre_tick = (pre_q == 16'd0);
	wire [1:0] mode = ctrl_q[1:0];
	wire multidrop = ctrl_q[2];
	wire local_loop = ctrl_q[3];
	wire remote_loop = ctrl_q[4];
	wire is_modem = (mode == `SCB_MODE_MOD8) || (mode == `SCB_MODE_MOD16);
	wire is_ac97 = (mode == `SCB_MODE_AC97);
	wire is_uart = (mode == `SCB_MODE_UART);
	wire [1:0] bpw = (mode == `SCB_MODE_UART || mode == `SCB_MODE_MOD8) ?
		2'd3 : (mode == `SCB_MODE_MOD16 ? 2'd1 : 2'd0);
	wire cmd_wr = wr && (addr == `SCB_OFF_CMD);
	wire [2:0] misc = wdata[`SCB_MISC_LSB+2:`SCB_MISC_LSB];
	wire [1:0] txc = wdata[`SCB_TXC_LSB+1:`SCB_TXC_LSB];
	wire [1:0] rxc = wdata[`SCB_RXC_LSB+1:`SCB_RXC_LSB];
	wire rx_tick, tx_tick;
	// RULE1 rx clock select
	scb_clk_sel u_rx_cs (
		.clk(clk),
		.resetn(resetn),
		.sel(clksel_q[`SCB_RXCS_LSB+3:`SCB_RXCS_LSB]),
		.prescaled_tick(pre_tick),
		.pin_rise(pin_rise),
		.tick(rx_tick)
	);
	// RULE2 tx clock select
	scb_clk_sel u_tx_cs (
		.clk(clk),
		.resetn(resetn),
		.sel(clksel_q[`SCB_TXCS_LSB+3:`SCB_TXCS_LSB]),
		.prescaled_tick(pre_tick),
		.pin_rise(pin_rise),
		.tick(tx_tick)
	);
	// ==============================
	// Tx FIFO: one entry per character or sample
	reg [19:0] txf_wd;
	reg [AW:0] txw_q, txr_q;
	reg [1:0] txsub_q;
	reg [31:0] txhold_q;
	reg txfill_q;
	wire [19:0] txf_rd;
	wire tx_empty_fifo = (txw_q == txr_q);
	wire tx_full = (txw_q[AW-1:0] == txr_q[AW-1:0]) && (txw_q[AW] != txr_q[AW]);
	reg txen_q, transmitter_empty_flag_q, transmitter_ready_flag_q, brk_q, brk_pend_q;
	// RULE13 modem fifo load
	wire tx_buf_wr = wr && (addr == `SCB_OFF_BUF) && (txen_q || is_modem)
		&& !txfill_q;
	// RULE22 upper word first
	always @*
	begin
		case (bpw)
			// Sub-word count runs down, so the top word leaves first
			2'd3: txf_wd = {12'h000, txhold_q[8*txsub_q+7 -: 8]};
			2'd1: txf_wd = {4'h0, txhold_q[16*txsub_q+15 -: 16]};
			default: txf_wd = txhold_q[19:0];
		endcase
	end
	wire txf_we = txfill_q && !tx_full;
	scb_fifo_mem #(.W(20), .AW(AW)) u_txf (
		.clk(clk),
		.we(txf_we),
		.waddr(txw_q[AW-1:0]),
		.wdata(txf_wd),
		.raddr(txr_q[AW-1:0]),
		.rdata(txf_rd)
	);
	// ==============================
	// Transmit shifter
	reg [1:0] ts_q;
	reg [19:0] tsh_q;
	reg [4:0] tbit_q;
	reg [1:0] brk_cnt_q;
	reg tx_stop_pend_q;
	wire [4:0] tbits = (bpw == 2'd3) ? 5'd10 : 5'd20;
	wire tx_busy = (ts_q != TS_IDLE);
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			clksel_q <= `SCB_CLKSEL_RST;
			ctrl_q <= `SCB_CTRL_RST;
			pre_q <= 16'd0;
			mode_ptr_reset <= 1'b0;
			txw_q <= {(AW+1){1'b0}};
			txr_q <= {(AW+1){1'b0}};
			txsub_q <= 2'd0;
			txhold_q <= 32'h00000000;
			txfill_q <= 1'b0;
			txen_q <= 1'b0;
			transmitter_empty_flag_q <= 1'b0;
			transmitter_ready_flag_q <= 1'b0;
			brk_q <= 1'b0;
			brk_pend_q <= 1'b0;
			ts_q <= TS_IDLE;
			tsh_q <= 20'h00000;
			tbit_q <= 5'd0;
			brk_cnt_q <= 2'd0;
			tx_stop_pend_q <= 1'b0;
			tx_line <= 1'b1;
		end
		else
		begin
			pre_q <= pre_tick ? PRESCALE[15:0] - 16'd1 : pre_q - 16'd1;
			if (wr && addr == `SCB_OFF_CLKSEL)
				clksel_q <= wdata[7:0];
			if (wr && addr == `SCB_OFF_CTRL)
				ctrl_q <= wdata[7:0];
			// RULE4 mode pointer
			mode_ptr_reset <= cmd_wr && (misc == `SCB_MISC_PTR);
			if (tx_buf_wr)
			begin
				txhold_q <= wdata;
				txsub_q <= bpw;
				txfill_q <= 1'b1;
			end
			else if (txf_we)
			begin
				txw_q <= txw_q + 1'b1;
				txsub_q <= cnt_sub(txsub_q);
				if (txsub_q == 2'd0)
					txfill_q <= 1'b0;
			end
			// Transmit state machine
			case (ts_q)
				TS_IDLE:
				begin
					tx_line <= !(brk_q && !brk_pend_q);
					if (brk_q && brk_pend_q && tx_tick)
						brk_pend_q <= 1'b0;
					else if (!brk_q && brk_cnt_q != 2'd0 && tx_tick)
						brk_cnt_q <= cnt_sub(brk_cnt_q);
					else if (!brk_q && brk_cnt_q == 2'd0 && txen_q
						&& !tx_empty_fifo && !tx_stop_pend_q)
						ts_q <= TS_LOAD;
					if (tx_stop_pend_q)
					begin
						txen_q <= 1'b0;
						tx_stop_pend_q <= 1'b0;
					end
				end
				TS_LOAD:
				begin
					tsh_q <= txf_rd;
					txr_q <= txr_q + 1'b1;
					tbit_q <= 5'd0;
					ts_q <= TS_SHIFT;
					transmitter_empty_flag_q <= 1'b0;
					if (is_uart || tx_empty_fifo)
						transmitter_ready_flag_q <= txen_q;
				end
				TS_SHIFT:
				begin
					if (tx_tick)
					begin
						if (tbit_q == 5'd0)
							tx_line <= 1'b0;
						else if (tbit_q == tbits - 5'd1)
							tx_line <= 1'b1;
						else
						begin
							tx_line <= tsh_q[0];
							tsh_q <= {1'b0, tsh_q[19:1]};
						end
						tbit_q <= tbit_q + 5'd1;
						if (tbit_q == tbits - 5'd1)
						begin
							ts_q <= TS_IDLE;
							if (tx_empty_fifo && is_uart)
								transmitter_empty_flag_q <= 1'b1;
						end
					end
				end
				default: ts_q <= TS_IDLE;
			endcase
			// RULE13 modem empty at sync
			if (is_modem && txen_q && fs_rise && tx_empty_fifo && !tx_busy)
				transmitter_empty_flag_q <= 1'b1;
			// RULE14 ac97 empty
			if (is_ac97 && txen_q && fs_rise && tx_empty_fifo && cr_s_q[1])
				transmitter_empty_flag_q <= 1'b1;
			if (cmd_wr)
			begin
				// RULE12 tx enable
				if (txc == `SCB_EN_CODE && !txen_q)
				begin
					txen_q <= 1'b1;
					tx_stop_pend_q <= 1'b0;
					if (is_uart)
					begin
						transmitter_empty_flag_q <= 1'b1;
						transmitter_ready_flag_q <= 1'b1;
					end
				end
				// RULE15 tx disable
				if (txc == `SCB_DIS_CODE && txen_q)
				begin
					tx_stop_pend_q <= 1'b1;
					if (!is_modem)
						transmitter_empty_flag_q <= 1'b0;
					if (!is_modem || remote_loop)
						transmitter_ready_flag_q <= 1'b0;
				end
				case (misc)
					// RULE6 tx reset
					`SCB_MISC_TXRST:
					begin
						txen_q <= 1'b0;
						tx_stop_pend_q <= 1'b0;
						ts_q <= TS_IDLE;
						tx_line <= 1'b1;
						transmitter_ready_flag_q <= 1'b0;
						if (!is_modem)
							transmitter_empty_flag_q <= 1'b0;
					end
					// RULE7 modem empty clear
					`SCB_MISC_ERRRST:
						if (is_modem)
							transmitter_empty_flag_q <= 1'b0;
					// RULE10 break accept
					`SCB_MISC_BRKON:
						if (txen_q && !is_modem)
						begin
							// RULE9 break start
							brk_q <= 1'b1;
							brk_pend_q <= 1'b1;
						end
					// RULE11 break stop
					`SCB_MISC_BRKOFF:
						if (brk_q)
						begin
							brk_q <= 1'b0;
							brk_cnt_q <= 2'd2;
						end
					default:
						brk_q <= brk_q;
				endcase
			end
		end
	end
	assign tx_enabled = txen_q;
	// ==============================
	// Receiver
	reg rxen_q, receiver_ready_flag_q, rxfull_q, fe_q, pe_q, oe_q, rbrk_q, db_q, sof_q;
	reg rs_q, rx_stop_pend_q;
	reg [4:0] rbit_q;
	reg [19:0] rsh_q;
	reg [AW:0] rxw_q, rxr_q;
	reg [19:0] rxf_wd;
	reg rxf_we;
	wire [19:0] rxf_rd;
	wire [AW:0] rx_cnt = rxw_q - rxr_q;
	wire rx_full = rx_cnt[AW];
	wire rx_last = (rs_q == RS_SHIFT) && rx_tick && (rbit_q == tbits - 5'd1);
	wire fe_set = rx_last && is_uart && !rx_in;
	wire oe_set = rx_last && rx_full;
	wire brk_set = fe_set && (rsh_q == 20'h00000);
	reg [31:0] rxwin_q;
	reg [2:0] rxwcnt_q;
	reg rxok_q;
	wire [2:0] rx_lim = {1'b0, bpw} + 3'd1;
	// RULE17 loopback keeps rx
	wire rx_run = rxen_q || local_loop || multidrop;
	wire buf_rd = rd && (addr == `SCB_OFF_BUF);
	wire rx_pop = rxok_q && !buf_rd && (rxwcnt_q < rx_lim);
	scb_fifo_mem #(.W(20), .AW(AW)) u_rxf (
		.clk(clk),
		.we(rxf_we),
		.waddr(rxw_q[AW-1:0]),
		.wdata(rxf_wd),
		.raddr(rxr_q[AW-1:0]),
		.rdata(rxf_rd)
	);
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rxen_q <= 1'b0;
			receiver_ready_flag_q <= 1'b0;
			rxfull_q <= 1'b0;
			fe_q <= 1'b0;
			pe_q <= 1'b0;
			oe_q <= 1'b0;
			rbrk_q <= 1'b0;
			db_q <= 1'b0;
			sof_q <= 1'b0;
			rs_q <= RS_IDLE;
			rx_stop_pend_q <= 1'b0;
			rbit_q <= 5'd0;
			rsh_q <= 20'h00000;
			rxw_q <= {(AW+1){1'b0}};
			rxr_q <= {(AW+1){1'b0}};
			rxf_wd <= 20'h00000;
			rxf_we <= 1'b0;
			rxwin_q <= 32'h00000000;
			rxwcnt_q <= 3'd0;
			rxok_q <= 1'b0;
		end
		else
		begin
			rxf_we <= 1'b0;
			if (rxf_we)
				rxw_q <= rxw_q + 1'b1;
			// Registered FIFO read is stale for one cycle after a pop
			rxok_q <= (rx_cnt != {(AW+1){1'b0}}) && !rx_pop;
			// RULE19 earliest in top byte
			if (buf_rd)
			begin
				rxwin_q <= 32'h00000000;
				rxwcnt_q <= 3'd0;
			end
			else if (rx_pop)
			begin
				rxr_q <= rxr_q + 1'b1;
				rxwcnt_q <= rxwcnt_q + 3'd1;
				// RULE20 two samples per read
				case (bpw)
					2'd3: rxwin_q[31-8*rxwcnt_q -: 8] <= rxf_rd[7:0];
					2'd1: rxwin_q[31-16*rxwcnt_q -: 16] <= rxf_rd[15:0];
					default: rxwin_q[19:0] <= rxf_rd;
				endcase
			end
			receiver_ready_flag_q <= (rx_cnt != {(AW+1){1'b0}}) || (rxwcnt_q != 3'd0);
			rxfull_q <= rx_full;
			sof_q <= is_ac97 && fs_rise;
			case (rs_q)
				RS_IDLE:
				begin
					if (rx_stop_pend_q)
					begin
						rxen_q <= 1'b0;
						rx_stop_pend_q <= 1'b0;
					end
					else if (rx_run && rx_tick && !rx_in)
					begin
						rs_q <= RS_SHIFT;
						rbit_q <= 5'd1;
					end
				end
				RS_SHIFT:
				begin
					if (rx_tick)
					begin
						rbit_q <= rbit_q + 5'd1;
						if (rbit_q == tbits - 5'd1)
						begin
							rs_q <= RS_IDLE;
							if (rx_full)
								oe_q <= 1'b1;
							else
							begin
								rxf_we <= 1'b1;
								// RULE21 tag slot placement
								rxf_wd <= (is_ac97 && sof_q) ?
									{rsh_q[19:4], 4'h0} : rsh_q;
							end
							if (is_uart && !rx_in)
								fe_q <= 1'b1;
							if (is_uart && !rx_in && rsh_q == 20'h00000)
							begin
								rbrk_q <= 1'b1;
								db_q <= 1'b1;
							end
						end
						else
							rsh_q <= (bpw == 2'd3) ?
								{12'h000, rx_in, rsh_q[7:1]} :
								{rx_in, rsh_q[19:1]};
					end
				end
				default: rs_q <= RS_IDLE;
			endcase
			if (cmd_wr)
			begin
				// RULE16 rx enable
				if (rxc == `SCB_EN_CODE && !rxen_q)
				begin
					rxen_q <= 1'b1;
					rx_stop_pend_q <= 1'b0;
					if (!multidrop)
						rs_q <= RS_IDLE;
				end
				if (rxc == `SCB_DIS_CODE && rxen_q)
				begin
					// RULE18 modem finishes char
					if (is_modem && rs_q == RS_SHIFT)
						rx_stop_pend_q <= 1'b1;
					// RULE17 rx disable drops char
					else
					begin
						rxen_q <= 1'b0;
						if (!local_loop && !multidrop)
							rs_q <= RS_IDLE;
					end
				end
				case (misc)
					// RULE5 rx reset
					`SCB_MISC_RXRST:
					begin
						rxen_q <= 1'b0;
						rx_stop_pend_q <= 1'b0;
						rs_q <= RS_IDLE;
						receiver_ready_flag_q <= 1'b0;
						rxfull_q <= 1'b0;
						rxr_q <= rxw_q;
						rxf_we <= 1'b0;
						rxwin_q <= 32'h00000000;
						rxwcnt_q <= 3'd0;
						rxok_q <= 1'b0;
					end
					// RULE7 error reset
					`SCB_MISC_ERRRST:
					begin
						// A flag raised in the same cycle survives
						rbrk_q <= brk_set;
						fe_q <= fe_set;
						pe_q <= 1'b0;
						oe_q <= oe_set;
					end
					// RULE8 delta break clear
					`SCB_MISC_DBRST:
						if (!is_modem)
							db_q <= brk_set;
					default:
						db_q <= db_q;
				endcase
			end
		end
	end
	assign rx_enabled = rxen_q;
	// ==============================
	// Read mux, data one cycle after strobe
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			rdata <= 32'h00000000;
		else if (rd)
		begin
			case (addr)
				// Packed receive window, emptied by this read
				`SCB_OFF_BUF: rdata <= rxwin_q;
				`SCB_OFF_IPC: rdata <= {24'h000000, 7'h00, fs_s_q[1]};
				`SCB_OFF_CTRL: rdata <= {24'h000000, ctrl_q};
				`SCB_OFF_STAT: rdata <= {21'h000000, sof_q,
					db_q, rbrk_q, fe_q, pe_q, oe_q, transmitter_empty_flag_q, transmitter_ready_flag_q,
					rxfull_q, receiver_ready_flag_q, brk_q};
				default: rdata <= 32'h00000000;
			endcase
		end
	end
endmodule // scb_core
`default_nettype wire

// File: verification/scb_core_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "scb_regs.vh"
// ==============================
// Command and line checks
module scb_core_props #(
	parameter AW = 4,
	parameter PRESCALE = 16
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [15:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic external_timer_pin,
	input wire logic rx_line,
	input wire logic frame_sync,
	input wire logic codec_ready,
	input wire logic tx_line,
	input wire logic mode_ptr_reset,
	input wire logic rx_enabled,
	input wire logic tx_enabled
);
	// Two bit-times plus sync slack
	localparam int BRK_MAX = 2 * PRESCALE + 4;
	logic pin_q;
	logic [3:0] age_q;
	logic [3:0] tcs_q;
	logic [4:0] ctl_q;
	wire cmd_w = wr && addr == `SCB_OFF_CMD;
	wire uart_mode = ctl_q[1:0] == `SCB_MODE_UART;
	wire ptr_cmd = cmd_w && wdata[6:4] == 3'h1;
	// Shadow of clock select and control, plus age of the last pin rise
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pin_q <= 1'h0;
			age_q <= 4'hF;
			tcs_q <= 4'h0;
			ctl_q <= 5'h00;
		end
		else
		begin
			pin_q <= external_timer_pin;
			if (external_timer_pin && !pin_q)
				age_q <= 4'h0;
			else if (age_q != 4'hF)
				age_q <= age_q + 4'h1;
			if (wr && addr == `SCB_OFF_CLKSEL)
				tcs_q <= wdata[3:0];
			if (wr && addr == `SCB_OFF_CTRL)
				ctl_q <= wdata[4:0];
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	sequence s_misc(logic [2:0] m);
		cmd_w && wdata[6:4] == m;
	endsequence
	sequence s_stop;
		cmd_w && wdata[6:4] == 3'h7 && tcs_q == `SCB_CS_PRESCALED && uart_mode;
	endsequence
	sequence s_mark;
		##[1:BRK_MAX] tx_line;
	endsequence
	chk_ptr_pulse:
	assert property (s_misc(3'h1) |=> mode_ptr_reset)
		else $error("pointer rewind pulse missing");
	chk_ptr_cause:
	assert property (mode_ptr_reset |-> $past(ptr_cmd))
		else $error("pointer rewind pulse without command");
	chk_cmd_noop:
	assert property (cmd_w && wdata[6:0] == 7'h00 |=> $stable(rx_enabled)
		&& $stable(tx_enabled) && !mode_ptr_reset) else $error("empty command acted");
	chk_tx_enable:
	assert property (cmd_w && wdata[3:2] == 2'h1 |=> tx_enabled [*2])
		else $error("transmitter not enabled");
	chk_tx_reset:
	assert property (cmd_w && wdata[6:4] == 3'h3 && uart_mode |=> !tx_enabled)
		else $error("transmitter reset left it enabled");
	chk_rx_enable:
	assert property (cmd_w && wdata[1:0] == 2'h1 |=> rx_enabled)
		else $error("receiver not enabled");
	chk_rx_reset:
	assert property (s_misc(3'h2) |=> !rx_enabled)
		else $error("receiver reset left it enabled");
	chk_rx_disable:
	assert property (cmd_w && wdata[1:0] == 2'h2 && ctl_q[3:0] == 4'h0
		|=> !rx_enabled) else $error("receiver disable ignored");
	chk_stop_break:
	assert property (s_stop |-> s_mark)
		else $error("line not back to mark in time");
	chk_break_off:
	assert property (cmd_w && wdata[6:4] == 3'h6 && !tx_enabled && tx_line
		|=> tx_line [*8]) else $error("break taken while disabled");
	chk_pin_clock:
	assert property (tcs_q == `SCB_CS_PIN && $changed(tx_line) |-> age_q <= 4'h8)
		else $error("line moved without a timer pin edge");
endmodule // scb_core_props
bind scb_core scb_core_props #(.AW(AW), .PRESCALE(PRESCALE)) scb_core_props_inst (
	.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata(rdata), .external_timer_pin(external_timer_pin), .rx_line(rx_line),
	.frame_sync(frame_sync), .codec_ready(codec_ready), .tx_line(tx_line),
	.mode_ptr_reset(mode_ptr_reset), .rx_enabled(rx_enabled),
	.tx_enabled(tx_enabled)
);
`default_nettype wire

// File: verification/scb_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ==============================
// Serial peer, timer pin runs free, one bit per pin period
module scb_peer (
	input wire logic clk,
	input wire logic tx_line,
	output wire logic external_timer_pin,
	output var logic rx_line,
	output var logic frame_sync,
	output var logic codec_ready
);
	logic [3:0] cnt_q = 4'h0;
	always @(posedge clk)
		cnt_q <= cnt_q + 4'h1;
	assign external_timer_pin = !cnt_q[3];
	// Codec stays not ready until a test raises it
	initial
	begin
		rx_line = 1'h1;
		frame_sync = 1'h0;
		codec_ready = 1'h0;
	end
	// Mid-bit point, well clear of the synced pin edge
	task automatic mid;
		@(posedge clk);
		while (cnt_q !== 4'h8)
			@(posedge clk);
	endtask
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'h1, b, 1'h0};
		for (int i = 0; i < 10; i++)
		begin
			mid;
			rx_line <= f[i];
		end
		mid;
	endtask
	task automatic recv_byte(output logic [7:0] b);
		int n;
		n = 0;
		mid;
		while (tx_line !== 1'h0 && n < 400)
		begin
			mid;
			n++;
		end
		for (int i = 0; i < 8; i++)
		begin
			mid;
			b[i] = tx_line;
		end
		mid;
	endtask
	task automatic sync_pulse;
		@(posedge clk);
		frame_sync <= 1'h1;
		repeat (4) @(posedge clk);
		frame_sync <= 1'h0;
	endtask
	task automatic codec_up;
		@(posedge clk);
		codec_ready <= 1'h1;
	endtask
endmodule // scb_peer
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "scb_regs.vh"
// ==============================
// Bench top
module tb_top;
	localparam int PRESC = 4;
	logic clk = 1'h0;
	logic resetn = 1'h0;
	logic wr = 1'h0;
	logic rd = 1'h0;
	logic [15:0] addr = 16'h0000;
	logic [31:0] wdata = 32'h00000000;
	logic [31:0] exp_tx = 32'h5AC30F81;
	logic [7:0] b;
	int num_errors = 0;
	int samples_checked = 0;
	wire [31:0] rdata;
	wire external_timer_pin, rx_line, frame_sync, codec_ready;
	wire tx_line, mode_ptr_reset, rx_enabled, tx_enabled;
	always #2.5 clk = ~clk;
	scb_core #(.PRESCALE(PRESC)) scb_core_inst (
		.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .external_timer_pin(external_timer_pin),
		.rx_line(rx_line), .frame_sync(frame_sync), .codec_ready(codec_ready),
		.tx_line(tx_line), .mode_ptr_reset(mode_ptr_reset),
		.rx_enabled(rx_enabled), .tx_enabled(tx_enabled)
	);
	scb_peer scb_peer_inst (
		.clk(clk), .tx_line(tx_line), .external_timer_pin(external_timer_pin),
		.rx_line(rx_line), .frame_sync(frame_sync), .codec_ready(codec_ready)
	);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic reg_wr(input logic [15:0] a, input logic [31:0] v);
		@(posedge clk);
		wr <= 1'h1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'h0;
		#1;
	endtask
	task automatic reg_rd(input logic [15:0] a, input logic [31:0] m,
		input logic [31:0] e);
		@(posedge clk);
		rd <= 1'h1;
		addr <= a;
		@(posedge clk);
		rd <= 1'h0;
		#1;
		chk(rdata & m, e);
	endtask
	// Bounded wait on the line (0) or the transmit enable (1)
	task automatic wait_for(input int w, input logic v);
		int n;
		n = 0;
		while ((w == 0 ? tx_line : tx_enabled) !== v && n < 400)
		begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic test_done;
		$display("Checks %0d, mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Watchdog, some thirty times the expected run
	initial
	begin
		repeat (40000) @(posedge clk);
		num_errors++;
		$display("Error at %0t: watchdog expired", $time);
		test_done;
	end
	initial
	begin
		repeat (2) @(posedge clk);
		resetn <= 1'h1;
		#1;
		chk({tx_line, tx_enabled, rx_enabled}, 32'h4);
		reg_rd(`SCB_OFF_STAT, 32'hFFFFFFFF, 32'h0);
		reg_rd(16'h2030, 32'hFFFFFFFF, 32'h0);
		$display("reset test done");
		reg_wr(`SCB_OFF_CLKSEL, 32'hFF);
		reg_wr(`SCB_OFF_CMD, 32'h04);
		reg_wr(`SCB_OFF_CMD, 32'h04);
		chk(tx_enabled, 32'h1);
		reg_rd(`SCB_OFF_STAT, 32'h18, 32'h18);
		reg_wr(`SCB_OFF_BUF, exp_tx);
		for (int i = 3; i >= 0; i--)
		begin
			scb_peer_inst.recv_byte(b);
			chk(b, exp_tx[i*8 +: 8]);
		end
		repeat (32) @(posedge clk);
		reg_rd(`SCB_OFF_STAT, 32'h10, 32'h10);
		reg_wr(`SCB_OFF_CMD, 32'h30);
		chk(tx_enabled, 32'h0);
		reg_rd(`SCB_OFF_STAT, 32'h18, 32'h0);
		reg_wr(`SCB_OFF_CMD, 32'h10);
		chk(mode_ptr_reset, 32'h1);
		reg_wr(`SCB_OFF_CMD, 32'h00);
		chk({mode_ptr_reset, tx_enabled, rx_enabled}, 32'h0);
		$display("transmit test done");
		reg_wr(`SCB_OFF_CMD, 32'h01);
		chk(rx_enabled, 32'h1);
		scb_peer_inst.send_byte(8'h3C);
		reg_rd(`SCB_OFF_STAT, 32'h2, 32'h2);
		scb_peer_inst.send_byte(8'h96);
		reg_rd(`SCB_OFF_STAT, 32'h2, 32'h2);
		reg_rd(`SCB_OFF_BUF, 32'hFFFFFFFF, 32'h3C960000);
		scb_peer_inst.send_byte(8'h5A);
		reg_wr(`SCB_OFF_CMD, 32'h20);
		chk(rx_enabled, 32'h0);
		reg_rd(`SCB_OFF_STAT, 32'h6, 32'h0);
		reg_wr(`SCB_OFF_CMD, 32'h01);
		reg_wr(`SCB_OFF_CMD, 32'h02);
		chk(rx_enabled, 32'h0);
		$display("receive test done");
		reg_wr(`SCB_OFF_CLKSEL, 32'hFD);
		reg_wr(`SCB_OFF_CMD, 32'h60);
		repeat (16) @(posedge clk);
		chk(tx_line, 32'h1);
		reg_wr(`SCB_OFF_CMD, 32'h04);
		reg_wr(`SCB_OFF_CMD, 32'h60);
		wait_for(0, 1'h0);
		chk(tx_line, 32'h0);
		reg_rd(`SCB_OFF_STAT, 32'h1, 32'h1);
		reg_wr(`SCB_OFF_CMD, 32'h70);
		wait_for(0, 1'h1);
		chk(tx_line, 32'h1);
		reg_wr(`SCB_OFF_CMD, 32'h08);
		wait_for(1, 1'h0);
		chk(tx_enabled, 32'h0);
		reg_rd(`SCB_OFF_STAT, 32'h18, 32'h0);
		$display("break test done");
		reg_wr(`SCB_OFF_CTRL, {30'h0, `SCB_MODE_MOD8});
		reg_wr(`SCB_OFF_CMD, 32'h04);
		reg_rd(`SCB_OFF_STAT, 32'h18, 32'h0);
		scb_peer_inst.sync_pulse;
		repeat (4) @(posedge clk);
		reg_rd(`SCB_OFF_STAT, 32'h10, 32'h10);
		reg_wr(`SCB_OFF_CMD, 32'h30);
		reg_rd(`SCB_OFF_STAT, 32'h10, 32'h10);
		reg_wr(`SCB_OFF_CMD, 32'h40);
		reg_rd(`SCB_OFF_STAT, 32'h10, 32'h0);
		$display("modem test done");
		reg_wr(`SCB_OFF_CTRL, {30'h0, `SCB_MODE_AC97});
		reg_wr(`SCB_OFF_CMD, 32'h04);
		scb_peer_inst.sync_pulse;
		repeat (4) @(posedge clk);
		reg_rd(`SCB_OFF_STAT, 32'h10, 32'h0);
		scb_peer_inst.codec_up;
		scb_peer_inst.sync_pulse;
		repeat (4) @(posedge clk);
		reg_rd(`SCB_OFF_STAT, 32'h10, 32'h10);
		$display("codec test done");
		test_done;
	end
endmodule // tb_top
`default_nettype wire
